// ==== adf_ctrl.sv ====
/*
  adc decimation filter control: apb register file, modulator rate
  enable, output period timing, settling and result strobe.
  assumes one 25 mhz clock, apb master, inputs synchronous to core_clk;
  the sinc3 datapath itself sits outside and follows filt_cfg.
*/
`timescale 1ns/100ps
`include "adf_cfg.svh"

module adf_ctrl
  import adf_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PER_W = 24
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_enable,
  input wire logic low_power_mode,
  output logic mod_tick,
  output adf_ctrl_s filt_cfg,
  output logic avg2_en,
  output logic adc_i_reset,
  output logic adc_vt_reset,
  output logic result_valid
);

  localparam logic [25:0] CORE_HZ = 26'(`ADF_CORE_HZ);
  localparam logic [25:0] MOD_STEP = 26'(`ADF_MOD_HZ);
  localparam logic [25:0] LP_STEP = 26'(`ADF_LP_HZ);
  localparam logic [10:0] STARTUP_CYC = 11'(`ADF_STARTUP_CYC);

  adf_ctrl_s ctrl_ff;
  adf_state_e state_ff;
  logic [25:0] phase_ff;
  logic mod_tick_ff;
  logic [PER_W-1:0] period_ff;
  logic [PER_W-1:0] per_cnt_ff;
  logic [2:0] settle_ff;
  logic [10:0] start_cnt_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic adc_rst_ff;
  logic result_valid_ff;
  logic avg2_ff;

  logic apb_done;
  logic ctrl_wr;
  logic ctrl_change;
  logic period_end;
  logic [25:0] nxt_phase;
  adf_ctrl_s nxt_ctrl;

  // output period in modulator ticks
  function automatic logic [PER_W-1:0] calc_period(
    input adf_ctrl_s c,
    input logic lp
  );
    logic [PER_W-1:0] base;
    logic [PER_W-1:0] mult;
    logic [PER_W-1:0] per;
    logic [PER_W-1:0] lim;
    if (c.decimation_factor == `ADF_SF_60) begin
      base = PER_W'(`ADF_MOD_HZ / `ADF_RATE_60);
    end else if (c.decimation_factor == `ADF_SF_50) begin
      base = PER_W'(`ADF_MOD_HZ / `ADF_RATE_50);
    end else begin
      base = (PER_W'(c.decimation_factor) + PER_W'(1))
        * PER_W'(`ADF_SF_MULT);
    end
    if (c.averaging_factor != 6'h00) begin
      // chop only triples the period while averaging is off; its fixed ticks are always added
      mult = PER_W'(`ADF_AF_BASE)
        + PER_W'(c.averaging_factor);
    end else if (c.chop) begin
      mult = PER_W'(`ADF_CHOP_DIV);
    end else begin
      mult = PER_W'(1);
    end
    per = PER_W'(base * mult);
    if (c.chop) begin
      per = per + PER_W'(`ADF_CHOP_ADD);
    end
    // datapath width caps the slowest update rate
    if (lp) begin
      lim = PER_W'(`ADF_LP_HZ / `ADF_MIN_RATE_LP);
    end else begin
      lim = PER_W'(`ADF_MOD_HZ / `ADF_MIN_RATE_NORM);
    end
    if (per > lim) begin
      per = lim;
    end
    return per;
  endfunction : calc_period

  // settling length in output periods
  function automatic logic [2:0] calc_settle(input adf_ctrl_s c);
    logic [2:0] s;
    if (c.chop) begin
      s = 3'(`ADF_SETTLE_CHOP);
    end else if (c.averaging_factor == 6'h00) begin
      s = 3'(`ADF_SETTLE_NOAF) + 3'(c.run_avg);
    end else begin
      s = 3'(`ADF_SETTLE_AF) + 3'(c.run_avg);
    end
    return s;
  endfunction : calc_settle

  // flags factor pairs outside the permitted table
  function automatic logic combo_bad(input adf_ctrl_s c);
    logic bad;
    bad = 1'b0;
    if (c.decimation_factor > 7'(`ADF_SF_LIM2)) begin
      bad = (c.averaging_factor != 6'h00);
    end else if (c.decimation_factor > 7'(`ADF_SF_LIM1)) begin
      bad = (c.averaging_factor > 6'(`ADF_AF_LIM2));
    end
    return bad;
  endfunction : combo_bad

  // register index from byte address, 2'h3 means unmapped
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [1:0] r;
    if (a == ADDR_W'(`ADF_CTRL_OFS)) begin
      r = 2'h0;
    end else if (a == ADDR_W'(`ADF_STAT_OFS)) begin
      r = 2'h1;
    end else begin
      r = 2'h3;
    end
    return r;
  endfunction : reg_sel

  assign apb_done = psel & penable & pready_ff;
  assign ctrl_wr = apb_done & pwrite & (reg_sel(paddr) == 2'h0);
  assign nxt_ctrl = adf_ctrl_s'(pwdata[15:0]);
  assign ctrl_change = ctrl_wr & (nxt_ctrl != ctrl_ff);
  assign period_end = mod_tick_ff & (per_cnt_ff >= period_ff - PER_W'(1));

  // one wait state keeps every apb output registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff
        & (reg_sel(paddr) == 2'h3);
    end
  end

  // status reads have no side effects; writes to it are dropped
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata_ff <= 32'h00000000;
    end else if (psel & penable & ~pready_ff & ~pwrite) begin
      case (reg_sel(paddr))
        2'h0: begin
          prdata_ff <= {16'h0000, ctrl_ff};
        end
        2'h1: begin
          prdata_ff <= {28'h0000000, state_ff == st_settle,
            low_power_mode, combo_bad(ctrl_ff), state_ff == st_run};
        end
        default: begin
          prdata_ff <= 32'h00000000;
        end
      endcase
    end
  end

  // upper write bits are ignored and read back as zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_ff <= adf_ctrl_s'(`ADF_CTRL_RST);
    end else if (ctrl_wr) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // a changed control value restarts both converters
  always_ff @(posedge core_clk) begin
    if (reset) begin
      adc_rst_ff <= 1'b0;
    end else begin
      adc_rst_ff <= ctrl_change;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      avg2_ff <= 1'b0;
    end else begin
      avg2_ff <= ctrl_ff.run_avg | ctrl_ff.chop;
    end
  end

  // fractional divider: no integer ratio exists from 25 mhz
  always_comb begin
    nxt_phase = phase_ff + (low_power_mode ? LP_STEP : MOD_STEP);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      phase_ff <= 26'h0000000;
      mod_tick_ff <= 1'b0;
    end else if (nxt_phase >= CORE_HZ) begin
      phase_ff <= nxt_phase - CORE_HZ;
      mod_tick_ff <= 1'b1;
    end else begin
      phase_ff <= nxt_phase;
      mod_tick_ff <= 1'b0;
    end
  end

  // follows the live power mode; a mode change does not restart
  always_ff @(posedge core_clk) begin
    if (reset) begin
      period_ff <= PER_W'(1);
    end else begin
      period_ff <= calc_period(ctrl_ff, low_power_mode);
    end
  end

  // period counter restarts with the converters
  always_ff @(posedge core_clk) begin
    if (reset) begin
      per_cnt_ff <= '0;
    end else if (state_ff != st_settle && state_ff != st_run) begin
      per_cnt_ff <= '0;
    end else if (ctrl_change) begin
      per_cnt_ff <= '0;
    end else if (period_end) begin
      per_cnt_ff <= '0;
    end else if (mod_tick_ff) begin
      per_cnt_ff <= per_cnt_ff + PER_W'(1);
    end
  end

  // startup wait counted in core cycles, not modulator ticks
  always_ff @(posedge core_clk) begin
    if (reset) begin
      start_cnt_ff <= 11'h000;
    end else if (state_ff == st_startup) begin
      start_cnt_ff <= start_cnt_ff + 11'h001;
    end else begin
      start_cnt_ff <= 11'h000;
    end
  end

  // a control change restarts settling but skips the startup wait
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff <= st_off;
      settle_ff <= 3'h0;
    end else if (!adc_enable) begin
      state_ff <= st_off;
      settle_ff <= 3'h0;
    end else begin
      case (state_ff)
        st_off: begin
          state_ff <= st_startup;
        end
        st_startup: begin
          if (start_cnt_ff == STARTUP_CYC - 11'h001) begin
            state_ff <= st_settle;
            settle_ff <= calc_settle(ctrl_ff);
          end
        end
        st_settle, st_run: begin
          if (ctrl_change) begin
            state_ff <= st_settle;
            settle_ff <= calc_settle(nxt_ctrl);
          end else if (state_ff == st_settle && period_end) begin
            if (settle_ff <= 3'h1) begin
              state_ff <= st_run;
              settle_ff <= 3'h0;
            end else begin
              settle_ff <= settle_ff - 3'h1;
            end
          end
        end
        default: begin
          state_ff <= st_off;
          settle_ff <= 3'h0;
        end
      endcase
    end
  end

  // the last settling period already yields a valid result
  always_ff @(posedge core_clk) begin
    if (reset) begin
      result_valid_ff <= 1'b0;
    end else if (!adc_enable || ctrl_change) begin
      result_valid_ff <= 1'b0;
    end else begin
      result_valid_ff <= period_end & ((state_ff == st_run)
        | (state_ff == st_settle & settle_ff <= 3'h1));
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign mod_tick = mod_tick_ff;
  assign filt_cfg = ctrl_ff;
  assign avg2_en = avg2_ff;
  assign adc_i_reset = adc_rst_ff;
  assign adc_vt_reset = adc_rst_ff;
  assign result_valid = result_valid_ff;

endmodule : adf_ctrl

// ==== adf_cfg.svh ====
/*
  constants of the adc decimation filter control block: register map,
  field positions, reset value, clock rates and timing counts.
  assumes inclusion by adf_ctrl.sv only; adf_pkg.sv does not include it.
*/
`ifndef ADF_CFG_SVH
`define ADF_CFG_SVH
`define ADF_CTRL_OFS 8'h00
`define ADF_STAT_OFS 8'h04
`define ADF_CTRL_RST 16'h0007
`define ADF_CHOP_BIT 15
`define ADF_RAVG_BIT 14
`define ADF_AF_MSB 13
`define ADF_AF_LSB 8
`define ADF_NOTCH_BIT 7
`define ADF_SF_MSB 6
`define ADF_CORE_HZ 25000000
`define ADF_CORE_NS 40
`define ADF_MOD_HZ 512000
`define ADF_LP_HZ 131000
`define ADF_SF_MULT 64
`define ADF_SF_60 7'h7e
`define ADF_SF_50 7'h7f
`define ADF_RATE_60 60
`define ADF_RATE_50 50
`define ADF_AF_BASE 3
`define ADF_CHOP_DIV 3
`define ADF_CHOP_ADD 3
`define ADF_MIN_RATE_NORM 4
`define ADF_MIN_RATE_LP 1
`define ADF_SETTLE_CHOP 2
`define ADF_SETTLE_NOAF 3
`define ADF_SETTLE_AF 1
`define ADF_STARTUP_NS 60000
`define ADF_STARTUP_CYC ((`ADF_STARTUP_NS + `ADF_CORE_NS - 1) / `ADF_CORE_NS)
`define ADF_SF_LIM1 31
`define ADF_SF_LIM2 63
`define ADF_AF_LIM2 7
`endif

// ==== adf_pkg.sv ====
/*
  types of the adc decimation filter control block.
  assumes adf_cfg.svh for the numbers.
*/
package adf_pkg;
  typedef struct packed {
    logic chop;
    logic run_avg;
    logic [5:0] averaging_factor;
    logic second_notch;
    logic [6:0] decimation_factor;
  } adf_ctrl_s;

  typedef enum logic [1:0] {
    st_off,
    st_startup,
    st_settle,
    st_run
  } adf_state_e;
endpackage : adf_pkg

// ==== adf_ctrl_asserts.sv ====
/*
  port assertions of adf_ctrl, bound to every instance.
  assumes the one-wait apb answer and one-cycle strobes of the block.
*/
`timescale 1ns/100ps
module adf_ctrl_asserts
  import adf_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc_enable,
  input wire logic mod_tick,
  input wire adf_ctrl_s filt_cfg,
  input wire logic avg2_en,
  input wire logic adc_i_reset,
  input wire logic adc_vt_reset,
  input wire logic result_valid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  addr_err_a: assert property (psel && penable && pready |->
    pslverr == (paddr != ADDR_W'(8'h00) && paddr != ADDR_W'(8'h04)))
    else $error("pslverr does not match address map");
  ctrl_write_a: assert property (psel && penable && pready && pwrite &&
    paddr == ADDR_W'(8'h00) |=> filt_cfg == $past(pwdata[15:0]))
    else $error("control write not stored");
  chop_avg_a: assert property (filt_cfg.chop |=> avg2_en)
    else $error("chop without pair averaging");
  avg_off_a: assert property (!filt_cfg.chop && !filt_cfg.run_avg |=> !avg2_en)
    else $error("pair averaging not bypassed");
  adc_reset_a: assert property ($changed(filt_cfg) |->
    ##[0:1] (adc_i_reset && adc_vt_reset))
    else $error("control change without adc resets");
  strobe_tick_a: assert property (result_valid |->
    $past(mod_tick) && !$past(result_valid))
    else $error("result strobe not one cycle after a tick");
  idle_quiet_a: assert property (!adc_enable ##1 !adc_enable |=> !result_valid)
    else $error("result strobe while disabled");
  tick_pulse_a: assert property (mod_tick |=> !mod_tick)
    else $error("modulator tick longer than one cycle");
endmodule : adf_ctrl_asserts

bind adf_ctrl adf_ctrl_asserts #(.ADDR_W(ADDR_W)) u_adf_ctrl_asserts (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .adc_enable(adc_enable), .mod_tick(mod_tick),
  .filt_cfg(filt_cfg), .avg2_en(avg2_en), .adc_i_reset(adc_i_reset),
  .adc_vt_reset(adc_vt_reset), .result_valid(result_valid));

// ==== adf_host.sv ====
/*
  host software model: apb master doing one transfer per call.
  assumes calls from the bench, one edge apart at least.
*/
`timescale 1ns/100ps
module adf_host (
  input wire logic core_clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // callers keep factor pairs legal
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no own limit: only the bench watchdog ends a hung wait
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : adf_host

// ==== tb_adc_decimation_filter_control.sv ====
/*
  self-checking bench of adf_ctrl: tick and strobe counts against a
  rate and settling model.
  assumes default parameters and the adf_host model.
*/
`timescale 1ns/100ps
module tb_adc_decimation_filter_control;
  import adf_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic adc_enable = 1'b0;
  logic low_power_mode = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic mod_tick, avg2_en, adc_i_reset, adc_vt_reset, result_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] seed = 32'h85240bd3;
  adf_ctrl_s filt_cfg;
  int bad_count = 0;
  int compares = 0;
  int ticks = 0;
  int strobes = 0;
  int rsts = 0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (adc_i_reset === 1'b1 && adc_vt_reset === 1'b1) rsts <= rsts + 1;
    if (mod_tick === 1'b1) ticks <= ticks + 1;
    if (result_valid === 1'b1) strobes <= strobes + 1;
  end
  adf_ctrl u_adf_ctrl (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_enable(adc_enable), .low_power_mode(low_power_mode),
    .mod_tick(mod_tick), .filt_cfg(filt_cfg), .avg2_en(avg2_en),
    .adc_i_reset(adc_i_reset), .adc_vt_reset(adc_vt_reset),
    .result_valid(result_valid));
  adf_host u_adf_host (.core_clk(core_clk), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int exp_per(input logic [15:0] v);
    int b;
    b = (int'(v[6:0]) + 1) * 64;
    if (v[13:8] != 6'h00) b = b * (3 + int'(v[13:8]));
    else if (v[15]) b = b * 3;
    return v[15] ? b + 3 : b;
  endfunction : exp_per
  function automatic int exp_set(input logic [15:0] v);
    if (v[15]) return 2;
    return (v[13:8] != 6'h00 ? 1 : 3) + int'(v[14]);
  endfunction : exp_set
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input int tol);
    compares++;
    if (got !== exp && (tol == 0 || $isunknown(got) || got > exp + tol
        || got + tol < exp)) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_strobe(input int s);
    for (int n = 0; n < 40000 && strobes <= s; n++) @(posedge core_clk);
    if (strobes <= s) begin
      bad_count++;
      $display("[FAIL] t=%0t strobes=%h exp>%h", $time, strobes, s);
    end
  endtask : wait_strobe
  task automatic run_cfg(input logic [15:0] v, input bit first);
    int t0;
    int s0;
    int r0;
    seed = lfsr(seed);
    r0 = rsts;
    u_adf_host.xfer(1'b1, 8'h00, {seed[31:16], v}, rd, err);
    u_adf_host.xfer(1'b0, 8'h00, 32'h0, rd, err);
    chk(rd, {16'h0, v}, 0);
    chk(rsts - r0, 1, 0);
    chk(32'(avg2_en), 32'(v[15] | v[14]), 0);
    if (first) begin
      adc_enable <= 1'b1;
      repeat (1501) @(posedge core_clk);
      chk(strobes, 0, 0);
    end
    t0 = ticks;
    s0 = strobes;
    wait_strobe(s0);
    chk(ticks - t0, exp_set(v) * exp_per(v), 1);
    if (exp_per(v) == 64) begin
      t0 = ticks;
      wait_strobe(s0 + 1);
      chk(ticks - t0, 64, 0);
    end
    $display("test cfg %h done", v);
  endtask : run_cfg
  task automatic complete_run;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  initial begin
    int s0;
    int t0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    u_adf_host.xfer(1'b0, 8'h00, 32'h0, rd, err);
    chk(rd, 32'h0000_0007, 0);
    for (int i = 126; i < 128; i++) begin
      u_adf_host.xfer(1'b1, 8'h00, 32'(i), rd, err);
      u_adf_host.xfer(1'b0, 8'h00, 32'h0, rd, err);
      chk(rd, 32'(i), 0);
    end
    u_adf_host.xfer(1'b0, 8'h10, 32'h0, rd, err);
    chk({rd[30:0], err}, 32'h1, 0);
    $display("test registers done");
    run_cfg(16'h0000, 1'b1);
    run_cfg(16'h4000, 1'b0);
    run_cfg(16'h0180, 1'b0);
    run_cfg(16'h8000, 1'b0);
    adc_enable <= 1'b0;
    @(posedge core_clk);
    s0 = strobes;
    repeat (4000) @(posedge core_clk);
    chk(strobes, s0, 0);
    $display("test disable done");
    t0 = ticks;
    repeat (5000) @(posedge core_clk);
    chk(ticks - t0, 5000 * 512 / 25000, 1);
    low_power_mode <= 1'b1;
    @(posedge core_clk);
    t0 = ticks;
    repeat (5000) @(posedge core_clk);
    chk(ticks - t0, 5000 * 131 / 25000, 1);
    $display("test tick rates done");
    complete_run();
  end
  initial begin
    repeat (95000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end
endmodule : tb_adc_decimation_filter_control
